// File: hdl/fnv_consts.svh
`ifndef FNV_CONSTS_SVH
`define FNV_CONSTS_SVH
// Behaviour
// - every frame opens with an 8-bit op-code from a set of eight.
// - chip select rising mid op-code discards it; nothing is performed.
// - latch set op-code 0x06 enables following writes; master sends it first.
// - latch clear op-code 0x04; with latch clear no writes happen.
// - status read 0x05 repeats status byte on so, si ignored.
// - status write 0x01 stores 8 bits, latch bit and bit 0 ignored.
// - array read 0x03, 16-bit address, top 2 bits ignored, bytes out.
// - each further read byte uses next address, wrapping to zero.
// - array write 0x02 commits each byte once its 8 bits arrive.
// - further write bytes go to incremented address, wrapping to zero.
// - fast read 0x0b adds 8 dummy bits after the address.
// - ident read 0x9f shifts 32-bit identifier, maker byte first.
// - after 32 identifier bits so holds the last bit.
// - block protect 00 none, 01 3000-3fff, 10 2000-3fff, 11 all.
// - latch clear blocks all; status locked when lock bit set and pin low.
// - pause pin low suspends command; sck, si ignored; so released on reads.
// - chip select rising during pause aborts the command.
// - abort before op-code recognised keeps the latch unchanged.
// - si sampled on rising sck, so changes on falling sck.
// - latch cleared at reset, clear command, end of recognised write.
// - chip select high deselects: inputs ignored, so released.
// - status: 7 lock, 6-4 spare, 3-2 block protect, 1 latch, 0 zero.
`define FNV_OP_LATCH_SET 8'h06
`define FNV_OP_LATCH_CLR 8'h04
`define FNV_OP_STAT_RD 8'h05
`define FNV_OP_STAT_WR 8'h01
`define FNV_OP_ARR_RD 8'h03
`define FNV_OP_ARR_WR 8'h02
`define FNV_OP_FAST_RD 8'h0B
`define FNV_OP_IDENT_RD 8'h9F
`define FNV_ADDR_W 14
`define FNV_DEPTH 16384
`define FNV_ST_LOCK 7
`define FNV_ST_BP_HI 3
`define FNV_ST_BP_LO 2
`define FNV_ST_LATCH 1
`define FNV_ST_RESET 8'h00
`define FNV_ST_WMASK 8'hFC
`define FNV_PROT_Q 14'h3000
`define FNV_PROT_H 14'h2000
`define FNV_ADDR_BITS 5'd16
`define FNV_DUMMY_BITS 5'd8
`define FNV_ID_BITS 6'd32
`define FNV_ID_DEFAULT 32'h0A5A_C3E1
`endif

// File: hdl/fnv_pkg.sv
package fnv_pkg;
	typedef enum logic [2:0] {
		FNV_OPCODE = 3'b000,
		FNV_ADDR = 3'b001,
		FNV_DUMMY = 3'b010,
		FNV_SHIFT_OUT = 3'b011,
		FNV_SHIFT_IN = 3'b100,
		FNV_IDLE = 3'b101
	} fnv_phase_e;
endpackage : fnv_pkg

// File: hdl/fnv_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser plus registered edge detect on the second stage
module fnv_sync (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic async_in,
	input wire logic reset_val,
	output logic sync_out,
	output logic rise,
	output logic fall
);
	logic meta_r;
	logic sync_r;
	logic prev_r;
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			prev_r <= 1'b0;
		end else begin
			meta_r <= async_in;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end
	// reset_val unused in logic beyond masking first edge
	assign sync_out = sync_r;
	assign rise = sync_r & ~prev_r & ~reset_val;
	assign fall = ~sync_r & prev_r & ~reset_val;
endmodule : fnv_sync

// File: hdl/fnv_engine.sv
`timescale 1ns/1ps
`include "fnv_consts.svh"
module fnv_engine import fnv_pkg::*; #(
	parameter logic [31:0] IDENT_CODE = `FNV_ID_DEFAULT // arbitrary value
) (
	// system
	input wire logic core_clk,
	input wire logic reset,
	// spi link pins
	input wire logic cs_n,
	input wire logic sck,
	input wire logic si,
	output logic so_o,
	output logic so_oe,
	// protection and pause pins
	input wire logic wp_n,
	input wire logic pause_n,
	// status view
	output logic [7:0] status_r
);
	logic cs_s, cs_rise, cs_fall;
	logic sck_s, sck_rise, sck_fall;
	logic si_s, wp_s, pause_s;
	logic blank_r;

	// blank_r also hides false edges of pins that idle high, since every synchroniser resets low
	fnv_sync u_cs (.core_clk(core_clk), .reset(reset), .async_in(cs_n), .reset_val(blank_r),
		.sync_out(cs_s), .rise(cs_rise), .fall(cs_fall));
	fnv_sync u_sck (.core_clk(core_clk), .reset(reset), .async_in(sck), .reset_val(blank_r),
		.sync_out(sck_s), .rise(sck_rise), .fall(sck_fall));
	fnv_sync u_si (.core_clk(core_clk), .reset(reset), .async_in(si), .reset_val(blank_r),
		.sync_out(si_s), .rise(), .fall());
	fnv_sync u_wp (.core_clk(core_clk), .reset(reset), .async_in(wp_n), .reset_val(blank_r),
		.sync_out(wp_s), .rise(), .fall());
	fnv_sync u_pause (.core_clk(core_clk), .reset(reset), .async_in(pause_n), .reset_val(blank_r),
		.sync_out(pause_s), .rise(), .fall());

	// cs_n synchroniser resets low; mask its first edges until settled
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			blank_r <= 1'b1;
		end else if (cs_s) begin
			blank_r <= 1'b0;
		end
	end

	logic [7:0] mem [0:`FNV_DEPTH-1];
	fnv_phase_e phase_r;
	logic [7:0] op_r;
	logic [7:0] shin_r;
	logic [7:0] shout_r;
	logic [5:0] cnt_r;
	logic [`FNV_ADDR_W-1:0] addr_r;
	logic [31:0] id_r;
	logic wr_seen_r;
	logic latch_r;
	logic [7:0] nv_status_r;
	logic active;
	logic held;
	logic [7:0] shin_nxt;
	logic bit_rise;
	logic bit_fall;
	logic byte_done;
	logic arr_prot;
	logic stat_prot;
	logic rd_cmd;

	// pause only acts while selected; edges seen during pause are dropped
	assign active = ~cs_s & ~blank_r;
	assign held = active & ~pause_s;
	assign bit_rise = active & ~held & sck_rise;
	assign bit_fall = active & ~held & sck_fall;
	assign shin_nxt = {shin_r[6:0], si_s};
	assign byte_done = bit_rise & (cnt_r[2:0] == 3'h7);
	assign rd_cmd = (op_r == `FNV_OP_ARR_RD) | (op_r == `FNV_OP_FAST_RD);

	always_comb begin
		unique case ({nv_status_r[`FNV_ST_BP_HI], nv_status_r[`FNV_ST_BP_LO]})
			2'b00: arr_prot = 1'b0;
			2'b01: arr_prot = addr_r >= `FNV_PROT_Q;
			2'b10: arr_prot = addr_r >= `FNV_PROT_H;
			2'b11: arr_prot = 1'b1;
		endcase
	end
	assign stat_prot = ~latch_r | (nv_status_r[`FNV_ST_LOCK] & ~wp_s);

	// command sequencer
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			phase_r <= FNV_IDLE;
			op_r <= 8'h00;
			shin_r <= 8'h00;
			cnt_r <= 6'h00;
			addr_r <= '0;
		end else if (!active) begin
			phase_r <= FNV_OPCODE;
			cnt_r <= 6'h00;
			op_r <= 8'h00;
		end else if (bit_rise) begin
			shin_r <= shin_nxt;
			cnt_r <= cnt_r + 6'h01;
			unique case (phase_r)
				FNV_OPCODE: begin
					if (cnt_r[2:0] == 3'h7) begin
						op_r <= shin_nxt;
						cnt_r <= 6'h00;
						unique case (shin_nxt)
							`FNV_OP_STAT_WR: phase_r <= FNV_SHIFT_IN;
							`FNV_OP_ARR_RD, `FNV_OP_ARR_WR, `FNV_OP_FAST_RD: phase_r <= FNV_ADDR;
							`FNV_OP_STAT_RD, `FNV_OP_IDENT_RD: phase_r <= FNV_SHIFT_OUT;
							default: phase_r <= FNV_IDLE;
						endcase
					end
				end
				FNV_ADDR: begin
					addr_r <= {addr_r[`FNV_ADDR_W-2:0], si_s};
					if (cnt_r[4:0] == `FNV_ADDR_BITS - 5'd1) begin
						cnt_r <= 6'h00;
						if (op_r == `FNV_OP_ARR_WR) phase_r <= FNV_SHIFT_IN;
						else if (op_r == `FNV_OP_FAST_RD) phase_r <= FNV_DUMMY;
						else phase_r <= FNV_SHIFT_OUT;
					end
				end
				FNV_DUMMY: begin
					if (cnt_r[4:0] == `FNV_DUMMY_BITS - 5'd1) begin
						cnt_r <= 6'h00;
						phase_r <= FNV_SHIFT_OUT;
					end
				end
				FNV_SHIFT_IN: begin
					if (byte_done && op_r == `FNV_OP_ARR_WR) begin
						addr_r <= addr_r + `FNV_ADDR_W'(1);
					end
				end
				FNV_SHIFT_OUT: begin
					if (byte_done && rd_cmd) begin
						addr_r <= addr_r + `FNV_ADDR_W'(1);
					end
					if (op_r == `FNV_OP_IDENT_RD && cnt_r == `FNV_ID_BITS) begin
						cnt_r <= cnt_r;
					end
				end
				FNV_IDLE: begin
					cnt_r <= cnt_r;
				end
			endcase
		end
	end

	// array commit; narrow check keeps write decode off the bit path
	always_ff @(posedge core_clk) begin
		if (phase_r == FNV_SHIFT_IN && op_r == `FNV_OP_ARR_WR && byte_done && latch_r && !arr_prot) begin
			mem[addr_r] <= shin_nxt;
		end
	end

	// nonvolatile status bits
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			nv_status_r <= `FNV_ST_RESET;
		end else if (phase_r == FNV_SHIFT_IN && op_r == `FNV_OP_STAT_WR && byte_done && !stat_prot) begin
			nv_status_r <= shin_nxt & `FNV_ST_WMASK;
		end
	end

	// write enable latch
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			latch_r <= 1'b0;
			wr_seen_r <= 1'b0;
		end else if (cs_rise) begin
			// unrecognised op-code leaves latch as is
			if (wr_seen_r) latch_r <= 1'b0;
			wr_seen_r <= 1'b0;
		end else if (phase_r == FNV_OPCODE && bit_rise && cnt_r[2:0] == 3'h7) begin
			if (shin_nxt == `FNV_OP_LATCH_SET) latch_r <= 1'b1;
			if (shin_nxt == `FNV_OP_LATCH_CLR) latch_r <= 1'b0;
			if (shin_nxt == `FNV_OP_STAT_WR || shin_nxt == `FNV_OP_ARR_WR) wr_seen_r <= 1'b1;
		end
	end

	// output shifter, loads a byte at each byte boundary of status and array reads and shifts on falling sck
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			shout_r <= 8'h00;
			id_r <= 32'h0000_0000;
			so_o <= 1'b0;
		end else if (!active) begin
			so_o <= 1'b0;
			id_r <= IDENT_CODE;
		end else if (bit_fall && phase_r == FNV_SHIFT_OUT) begin
			if (op_r == `FNV_OP_IDENT_RD) begin
				so_o <= id_r[31];
				if (cnt_r < `FNV_ID_BITS) id_r <= {id_r[30:0], id_r[0]};
			end else if (cnt_r[2:0] == 3'h0) begin
				so_o <= rd_cmd ? mem[addr_r][7] : status_r[7];
				shout_r <= {rd_cmd ? mem[addr_r][6:0] : status_r[6:0], 1'b0};
			end else begin
				so_o <= shout_r[7];
				shout_r <= {shout_r[6:0], 1'b0};
			end
		end
	end

	// output enable: released when deselected or paused
	// drv_r remembers that so carries data, so so drives again once a pause ends
	logic drv_r;
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			drv_r <= 1'b0;
			so_oe <= 1'b0;
		end else if (!active) begin
			drv_r <= 1'b0;
			so_oe <= 1'b0;
		end else if (bit_fall && phase_r == FNV_SHIFT_OUT) begin
			drv_r <= 1'b1;
			so_oe <= 1'b1;
		end else begin
			so_oe <= drv_r & ~held;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			status_r <= 8'h00;
		end else begin
			status_r <= {nv_status_r[7:2], latch_r, 1'b0};
		end
	end
endmodule : fnv_engine

// File: testbench/fnv_engine_sva.sv
`timescale 1ns/1ps
module fnv_engine_sva (
	// system
	input wire logic core_clk,
	input wire logic reset,
	// link
	input wire logic cs_n,
	input wire logic sck,
	input wire logic so_o,
	input wire logic so_oe,
	// pins and status
	input wire logic wp_n,
	input wire logic pause_n,
	input wire logic [7:0] status_r
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	// windows of 6 to 8 cycles cover the pin synchroniser lag
	a_desel_float: assert property (cs_n [*6] |-> !so_oe) else $error("so driven while deselected");
	a_pause_float: assert property ((!pause_n && !cs_n) [*6] |-> !so_oe) else $error("so driven in pause");
	a_oe_cause: assert property ($rose(so_oe) |-> !cs_n && pause_n) else $error("so enabled without cause");
	a_so_hold: assert property ((sck && !cs_n) [*8] |=> $stable(so_o)) else $error("so moved with sck high");
	a_bit0_zero: assert property (!status_r[0]) else $error("status bit 0 set");
	a_status_idle: assert property (cs_n [*8] |=> $stable(status_r)) else $error("status moved while idle");
	a_latch_guard: assert property (!status_r[1] |=> $stable(status_r[7:2])) else $error("write with latch clear");
	a_wp_lock: assert property (status_r[7] && !wp_n |=> $stable(status_r[7:2])) else $error("locked status written");
endmodule : fnv_engine_sva
bind fnv_engine fnv_engine_sva u_sva (.core_clk, .reset, .cs_n, .sck, .so_o, .so_oe, .wp_n, .pause_n, .status_r);

// File: testbench/fnv_spi_host.sv
`timescale 1ns/1ps
module fnv_spi_host (
	// system
	input wire logic core_clk,
	// link
	output logic cs_n,
	output logic sck,
	output logic si,
	input wire logic so_o,
	input wire logic so_oe,
	// pause
	output logic pause_n
);
	logic [7:0] rxs;
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		si = 1'b0;
		pause_n = 1'b1;
		rxs = 8'h00;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask : tick
	// mode 0, 80 ns sck; a released so reads as unknown
	task automatic bits(input logic [7:0] tx, input int n);
		for (int i = 7; i > 7 - n; i--) begin
			si <= tx[i];
			tick(10);
			rxs = {rxs[6:0], so_oe ? so_o : 1'bx};
			sck <= 1'b1;
			tick(10);
			sck <= 1'b0;
		end
	endtask : bits
	task automatic sel(input logic v);
		tick(4);
		cs_n <= v;
		tick(8);
	endtask : sel
	// a stray sck pulse in pause, then release at the starting level
	task automatic hold(input logic ab);
		// let the last sck fall land before pausing
		tick(6);
		pause_n <= 1'b0;
		tick(6);
		sck <= ~sck;
		tick(10);
		sck <= ~sck;
		tick(6);
		if (ab) cs_n <= 1'b1;
		tick(6);
		pause_n <= 1'b1;
	endtask : hold
endmodule : fnv_spi_host

// File: testbench/spi_nv_memory_command_engine_tb_top.sv
`timescale 1ns/1ps
module spi_nv_memory_command_engine_tb_top;
	localparam logic [31:0] IDC = 32'h3C96_1E87; // arbitrary value
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic wp_n = 1'b1;
	wire logic cs_n, sck, si, so_o, so_oe, pause_n;
	wire logic [7:0] status_r;
	int errors = 0;
	int cmp_count = 0;
	logic [7:0] st = 8'h00;
	logic [7:0] mem [16384];
	always #2 core_clk = ~core_clk;
	fnv_engine #(.IDENT_CODE(IDC)) uut (.core_clk, .reset, .cs_n, .sck, .si, .so_o, .so_oe, .wp_n, .pause_n, .status_r);
	fnv_spi_host host (.core_clk, .cs_n, .sck, .si, .so_o, .so_oe, .pause_n);
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic end_of_test;
		if (errors == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : end_of_test
	function automatic logic prot(input logic [13:0] p);
		case (st[3:2])
			2'b00: return 1'b0;
			2'b01: return p >= 14'h3000;
			2'b10: return p >= 14'h2000;
			default: return 1'b1;
		endcase
	endfunction : prot
	task automatic cmd(input logic [7:0] op, input logic [15:0] a, input int n);
		host.sel(1'b0);
		host.bits(op, 8);
		for (int i = 0; i < n; i++) host.bits(i < 2 ? a[15 - 8 * i -: 8] : 8'($urandom), 8);
	endtask : cmd
	task automatic fin(input logic [7:0] nst);
		host.sel(1'b1);
		st = nst;
		chk(status_r, st);
	endtask : fin
	task automatic latch_on;
		cmd(8'h06, 16'h0000, 0);
		fin(st | 8'h02);
	endtask : latch_on
	task automatic status_write_cmd(input logic [7:0] v);
		logic ok;
		ok = st[1] && !(st[7] && !wp_n);
		cmd(8'h01, 16'h0000, 0);
		host.bits(v, 8);
		fin(ok ? {v[7:2], 2'b00} : (st & 8'hFD));
	endtask : status_write_cmd
	task automatic xfer(input logic [7:0] op, input logic [15:0] a, input int n);
		logic [13:0] p;
		logic [7:0] d;
		p = a[13:0];
		cmd(op, a, op == 8'h0B ? 3 : 2);
		repeat (n) begin
			d = 8'($urandom);
			host.bits(d, 8);
			if (op != 8'h02) chk(host.rxs, mem[p]);
			else if (st[1] && !prot(p)) mem[p] = d;
			p++;
		end
		fin(op == 8'h02 ? (st & 8'hFD) : st);
	endtask : xfer
	initial begin
		logic [15:0] a;
		void'($urandom(32'h7635));
		repeat (3) @(posedge core_clk);
		reset <= 1'b0;
		status_write_cmd(8'hFC);
		host.sel(1'b0);
		host.bits(8'h06, 4);
		fin(st);
		latch_on;
		cmd(8'h05, 16'h0000, 0);
		repeat (2) begin
			host.bits(8'($urandom), 4);
			host.hold(1'b0);
			host.bits(8'($urandom), 4);
			chk(host.rxs, st);
		end
		fin(st);
		host.sel(1'b0);
		host.bits(8'h04, 5);
		host.hold(1'b1);
		fin(st);
		cmd(8'h04, 16'h0000, 0);
		fin(st & 8'hFD);
		for (int b = 0; b < 4; b++) begin
			latch_on;
			status_write_cmd({1'b0, 3'($urandom), 2'(b), 2'b00});
			for (int j = 0; j < 2; j++) begin
				a = {2'($urandom), j ? 14'h3FFE : 14'h2FFE};
				latch_on;
				xfer(8'h02, a, 4);
				xfer(b[0] ? 8'h0B : 8'h03, a, 4);
			end
		end
		cmd(8'h9F, 16'h0000, 0);
		for (int i = 0; i < 5; i++) begin
			host.bits(8'($urandom), 8);
			chk(host.rxs, i < 4 ? IDC[31 - 8 * i -: 8] : {8{IDC[0]}});
		end
		fin(st);
		// wp_n moves only between frames
		latch_on;
		status_write_cmd(8'h80);
		wp_n <= 1'b0;
		latch_on;
		status_write_cmd(8'h0C);
		wp_n <= 1'b1;
		latch_on;
		status_write_cmd(8'h00);
		end_of_test;
	end
	initial begin
		repeat (100000) @(posedge core_clk);
		errors++;
		end_of_test;
	end
endmodule : spi_nv_memory_command_engine_tb_top
